/* File: logic/spc_serial_port.sv */
`timescale 1ns/1ps
module spc_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp, rp;
      logic [AW:0] cnt;
   } spc_fifo_s;
   spc_fifo_s q, n;
   logic push, pop;

   always_comb begin
      n = q;
      in_ready = q.cnt != (AW+1)'(D);
      out_valid = q.cnt != '0;
      out_data = q.mem[q.rp];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push) begin
         n.mem[q.wp] = in_data;
         n.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
      end
      if (pop) begin
         n.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
      end
      n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule : spc_fifo

module spc_serial_port import spc_pkg::*; #(
   parameter int FIFO_DEPTH = SPC_FIFO_DEPTH
) (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire spc_sfr_req_s SFR_REQ,
   output logic [7:0] SFR_RDATA,
   input wire logic BAUD_TICK,
   input wire logic RXD_I,
   output logic RXD_O,
   output logic RXD_OE,
   output logic TXD_O,
   output logic TX_READY
);
   spc_state_s q, n;
   logic ctl_wr, buf_wr, pwr_wr, m0, m1, m2, stp, accept;
   logic set_ti, set_ri, set_fe, sclk, f_valid, f_pop;
   logic [1:0] mode;
   logic [6:0] per;
   logic [3:0] nbits, ndata;
   logic [7:0] f_data, w;

   spc_fifo #(.W(8), .D(FIFO_DEPTH)) u_txq (
      .clk(MCLK),
      .rst(SYS_RST),
      .in_valid(buf_wr),
      .in_ready(TX_READY),
      .in_data(SFR_REQ.wdata),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   always_comb begin
      n = q;
      w = SFR_REQ.wdata;
      ctl_wr = SFR_REQ.wr && SFR_REQ.addr == SPC_ADDR_CTRL;
      buf_wr = SFR_REQ.wr && SFR_REQ.addr == SPC_ADDR_BUF;
      pwr_wr = SFR_REQ.wr && SFR_REQ.addr == SPC_ADDR_PWR;
      mode = {q.sm0, q.sm1};
      m0 = mode == SPC_MODE0;
      m1 = mode == SPC_MODE1;
      m2 = mode == SPC_MODE2;
      if (m0) begin
         per = q.sm2 ? SPC_M0_DIV_FAST : SPC_M0_DIV_SLOW;
      end else begin
         per = (m2 ? SPC_M2_DIV : SPC_TICKS_PER_BIT) >> q.bdbl;
      end
      stp = m0 || m2 || BAUD_TICK;
      nbits = m1 ? SPC_BITS_M1 : SPC_BITS_M23;
      ndata = (m0 || m1) ? SPC_BITS_8 : SPC_BITS_9;
      set_ti = 1'b0;
      set_ri = 1'b0;
      set_fe = 1'b0;
      f_pop = 1'b0;
      accept = 1'b0;
      if (pwr_wr) begin
         n.bdbl = w[SPC_B_BDBL];
         n.fe_sel = w[SPC_B_FESEL];
      end
      if (ctl_wr) begin
         if (q.fe_sel) begin
            n.fe = w[SPC_B_SM0];
         end else begin
            n.sm0 = w[SPC_B_SM0];
         end
         n.sm1 = w[SPC_B_SM1];
         n.sm2 = w[SPC_B_SM2];
         n.ren = w[SPC_B_REN];
         n.tb8 = w[SPC_B_TB8];
         n.rb8 = w[SPC_B_RB8];
         n.ti = w[SPC_B_TI];
         n.ri = w[SPC_B_RI];
      end
      // transmitter; mode 0 waits for an idle receiver on the shared pin
      if (!q.tx_busy) begin
         if (f_valid && !(m0 && q.rx_st != SPC_RX_IDLE)) begin
            f_pop = 1'b1;
            n.tx_busy = 1'b1;
            n.tx_cnt = '0;
            n.tx_bits = '0;
            if (m0) begin
               n.tx_sh = {3'h7, f_data};
            end else begin
               n.tx_sh = {1'b1, m1 | q.tb8, f_data, 1'b0};
            end
         end
      end else if (stp) begin
         if (q.tx_cnt == per - 7'h1) begin
            n.tx_cnt = '0;
            n.tx_sh = {1'b1, q.tx_sh[10:1]};
            n.tx_bits = q.tx_bits + 4'h1;
            if (m0 && q.tx_bits == SPC_BITS_8 - 4'h1) begin
               set_ti = 1'b1;
               n.tx_busy = 1'b0;
            end else if (!m0 && q.tx_bits == nbits - 4'h2) begin
               set_ti = 1'b1;
            end else if (!m0 && q.tx_bits == nbits - 4'h1) begin
               n.tx_busy = 1'b0;
            end
         end else begin
            n.tx_cnt = q.tx_cnt + 7'h1;
         end
      end
      // receiver
      case (q.rx_st)
         SPC_RX_IDLE: begin
            if (q.ren) begin
               if (m0) begin
                  if (!q.ri && !q.tx_busy && !f_valid) begin
                     n.rx_st = SPC_RX_DATA;
                     n.rx_cnt = '0;
                     n.rx_bits = '0;
                  end
               end else if (q.rxd_q && !RXD_I) begin
                  n.rx_st = SPC_RX_START;
                  n.rx_cnt = '0;
               end
            end
         end
         SPC_RX_START: begin
            if (stp) begin
               if (q.rx_cnt == (per >> 1) - 7'h1) begin
                  n.rx_st = RXD_I ? SPC_RX_IDLE : SPC_RX_DATA;
                  n.rx_cnt = '0;
                  n.rx_bits = '0;
               end else begin
                  n.rx_cnt = q.rx_cnt + 7'h1;
               end
            end
         end
         SPC_RX_DATA: begin
            if (stp) begin
               if (q.rx_cnt == per - 7'h1) begin
                  n.rx_cnt = '0;
                  n.rx_sh = {RXD_I, q.rx_sh[8:1]};
                  n.rx_bits = q.rx_bits + 4'h1;
                  if (q.rx_bits == ndata - 4'h1) begin
                     if (m0) begin
                        set_ri = 1'b1;
                        n.rx_buf = n.rx_sh[8:1];
                        n.rx_st = SPC_RX_IDLE;
                     end else begin
                        n.rx_st = SPC_RX_STOP;
                     end
                  end
               end else begin
                  n.rx_cnt = q.rx_cnt + 7'h1;
               end
            end
         end
         SPC_RX_STOP: begin
            if (stp) begin
               if (q.rx_cnt == per - 7'h1) begin
                  n.rx_st = SPC_RX_IDLE;
                  accept = !q.sm2 || (m1 ? RXD_I : q.rx_sh[8]);
                  if (accept) begin
                     set_ri = 1'b1;
                     n.rx_buf = m1 ? q.rx_sh[8:1] : q.rx_sh[7:0];
                     n.rb8 = m1 ? RXD_I : q.rx_sh[8];
                  end
                  set_fe = q.fe_sel && !RXD_I;
               end else begin
                  n.rx_cnt = q.rx_cnt + 7'h1;
               end
            end
         end
         default: n.rx_st = SPC_RX_IDLE;
      endcase
      // hardware set wins over a software clear in the same cycle
      n.ti = n.ti | set_ti;
      n.ri = n.ri | set_ri;
      n.fe = n.fe | set_fe;
      n.rxd_q = RXD_I;
      if (m0 && n.tx_busy) begin
         sclk = n.tx_cnt >= (per >> 1);
      end else if (m0 && n.rx_st == SPC_RX_DATA) begin
         sclk = n.rx_cnt >= (per >> 1);
      end else begin
         sclk = 1'b1;
      end
      n.txd_o = m0 ? sclk : (n.tx_busy ? n.tx_sh[0] : 1'b1);
      n.rxd_o = n.tx_sh[0];
      n.rxd_oe = m0 && n.tx_busy;
      if (SFR_REQ.rd) begin
         case (SFR_REQ.addr)
            SPC_ADDR_CTRL: n.rdata = {q.fe_sel ? q.fe : q.sm0, q.sm1,
               q.sm2, q.ren, q.tb8, q.rb8, q.ti, q.ri};
            SPC_ADDR_BUF: n.rdata = q.rx_buf;
            SPC_ADDR_PWR: n.rdata = {q.bdbl, q.fe_sel, 6'h00};
            default: n.rdata = SPC_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         q <= '0;
         q.rx_st <= SPC_RX_IDLE;
         q.rxd_q <= 1'b1;
         q.txd_o <= 1'b1;
         q.rxd_o <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign SFR_RDATA = q.rdata;
   assign TXD_O = q.txd_o;
   assign RXD_O = q.rxd_o;
   assign RXD_OE = q.rxd_oe;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);

   ti_sticky_a: assert property (q.ti && !ctl_wr |=> q.ti)
      else $error("transmit done flag dropped by hardware");
   ri_sticky_a: assert property (q.ri && !ctl_wr |=> q.ri)
      else $error("receive done flag dropped by hardware");
   fe_sticky_a: assert property (q.fe && !ctl_wr |=> q.fe)
      else $error("frame error flag dropped by hardware");
   rx_disabled_a: assert property (
      q.rx_st == SPC_RX_IDLE && !q.ren |=> q.rx_st == SPC_RX_IDLE)
      else $error("receiver left idle while disabled");
   buf_write_a: assert property (buf_wr && !set_ri |=> $stable(q.rx_buf))
      else $error("transmit write changed receive buffer");
   mp_ninth_a: assert property (
      $rose(q.ri) && !$past(ctl_wr) && q.sm0 && q.sm2 && !q.fe_sel
      |-> q.rb8)
      else $error("receive done with ninth bit zero in filter mode");
   mp_stop_a: assert property (
      $rose(q.ri) && !$past(ctl_wr) && m1 && q.sm2 |-> $past(RXD_I))
      else $error("receive done without valid stop bit in mode 1");
   m0_slow_a: assert property (
      $fell(TXD_O) && m0 && !q.sm2 && q.tx_busy && !$past(ctl_wr)
      |-> !TXD_O [*6])
      else $error("mode 0 slow clock low phase not six cycles");
   m0_fast_a: assert property (
      $fell(TXD_O) && m0 && q.sm2 && q.tx_busy && !$past(ctl_wr)
      |-> !TXD_O [*2] ##1 TXD_O)
      else $error("mode 0 fast clock low phase not two cycles");
endmodule : spc_serial_port

/* File: logic/spc_pkg.sv */
package spc_pkg;
   localparam logic [7:0] SPC_ADDR_CTRL = 8'h98;
   localparam logic [7:0] SPC_ADDR_BUF = 8'h99;
   localparam logic [7:0] SPC_ADDR_PWR = 8'h87;
   localparam logic [7:0] SPC_UNMAPPED = 8'hff;
   localparam int SPC_B_SM0 = 7;
   localparam int SPC_B_SM1 = 6;
   localparam int SPC_B_SM2 = 5;
   localparam int SPC_B_REN = 4;
   localparam int SPC_B_TB8 = 3;
   localparam int SPC_B_RB8 = 2;
   localparam int SPC_B_TI = 1;
   localparam int SPC_B_RI = 0;
   localparam int SPC_B_BDBL = 7;
   localparam int SPC_B_FESEL = 6;
   localparam logic [1:0] SPC_MODE0 = 2'h0;
   localparam logic [1:0] SPC_MODE1 = 2'h1;
   localparam logic [1:0] SPC_MODE2 = 2'h2;
   localparam int SPC_CNT_W = 7;
   localparam logic [6:0] SPC_M0_DIV_SLOW = 7'h0c;
   localparam logic [6:0] SPC_M0_DIV_FAST = 7'h04;
   localparam logic [6:0] SPC_M2_DIV = 7'h40;
   localparam logic [6:0] SPC_TICKS_PER_BIT = 7'h20;
   localparam logic [3:0] SPC_BITS_8 = 4'h8;
   localparam logic [3:0] SPC_BITS_9 = 4'h9;
   localparam logic [3:0] SPC_BITS_M1 = 4'ha;
   localparam logic [3:0] SPC_BITS_M23 = 4'hb;
   localparam int SPC_FIFO_DEPTH = 8;

   typedef enum logic [3:0] {
      SPC_RX_IDLE = 4'h1,
      SPC_RX_START = 4'h2,
      SPC_RX_DATA = 4'h4,
      SPC_RX_STOP = 4'h8
   } spc_rx_e;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } spc_sfr_req_s;

   typedef struct packed {
      logic sm0, sm1, sm2, ren, tb8, rb8, ti, ri, fe;
      logic fe_sel, bdbl;
      logic [7:0] rx_buf;
      logic [7:0] rdata;
      logic tx_busy;
      logic [10:0] tx_sh;
      logic [3:0] tx_bits;
      logic [SPC_CNT_W-1:0] tx_cnt;
      spc_rx_e rx_st;
      logic [8:0] rx_sh;
      logic [3:0] rx_bits;
      logic [SPC_CNT_W-1:0] rx_cnt;
      logic rxd_q, txd_o, rxd_o, rxd_oe;
   } spc_state_s;
endpackage : spc_pkg

/* File: tb/spc_link_model.sv */
`timescale 1ns/1ps
module spc_link_model (
   input wire logic clk,
   output logic rxd
);
   initial rxd = 1'b1;
   // start, eight data bits lsb first, ninth bit, stop; idle line high
   task automatic send(input logic [7:0] d, input logic b9,
         input logic stp, input int bt);
      logic [10:0] f;
      f = {stp, b9, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         rxd <= f[i];
         repeat (bt - 1) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
   endtask : send
endmodule : spc_link_model

/* File: tb/serial_port_control_tb.sv */
`timescale 1ns/1ps
module serial_port_control_tb import spc_pkg::*; ;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   spc_sfr_req_s req = '0;
   logic tick = 1'b0;
   logic [1:0] tcnt = 2'h0;
   logic [7:0] rdata, v, d, lastr;
   logic txd, rxd_o, rxd_oe, tx_ready, line, rxd_m, b, lb9;
   logic [31:0] seed = 32'hca8a8442;
   int mismatches = 0;
   int samples_checked = 0;
   int n;
   logic [10:0] f;
   logic [10:0] fr [8];
   logic [7:0] sent [$];
   logic [7:0] cc [5] = '{8'h90, 8'hb0, 8'hb0, 8'h80, 8'h90};
   logic [7:0] mk [5] = '{8'h85, 8'h85, 8'h85, 8'h85, 8'h80};
   logic [4:0] b9v = 5'b11101;
   logic [4:0] stv = 5'b01111;
   logic [4:0] acv = 5'b00101;
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
   end
   assign line = rxd_oe ? rxd_o : rxd_m;
   spc_serial_port #(.FIFO_DEPTH(SPC_FIFO_DEPTH)) spc_serial_port_i (
      .MCLK(mclk), .SYS_RST(sys_rst), .SFR_REQ(req), .SFR_RDATA(rdata),
      .BAUD_TICK(tick), .RXD_I(line), .RXD_O(rxd_o), .RXD_OE(rxd_oe),
      .TXD_O(txd), .TX_READY(tx_ready));
   spc_link_model spc_link_model_i (.clk(mclk), .rxd(rxd_m));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [10:0] frame(input logic [7:0] x,
         input logic b9);
      return {1'b1, b9, x, 1'b0};
   endfunction : frame
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [10:0] e, g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one register access; write data lands at the taken edge
   task automatic acc(input logic [7:0] a, input logic w,
         input logic [7:0] wd, output logic [7:0] q);
      @(posedge mclk);
      req <= '{addr: a, wr: w, rd: !w, wdata: wd};
      @(posedge mclk);
      req <= '0;
      #1 q = rdata;
   endtask : acc
   task automatic rchk(input string nm, input logic [7:0] a, m, e);
      logic [7:0] q;
      acc(a, 1'b0, 8'h00, q);
      chk(nm, {3'h0, e}, {3'h0, q & m});
   endtask : rchk
   task automatic wait_low(input int lim);
      int k;
      k = 0;
      while (txd !== 1'b0) begin
         @(posedge mclk);
         #1;
         k++;
         if (k > lim) begin
            chk("txd_start", 11'h0, {10'h0, txd});
            conclude();
         end
      end
   endtask : wait_low
   // samples each bit in its middle
   task automatic decode(input int bt, output logic [10:0] o);
      wait_low(3000);
      repeat (bt / 2) @(posedge mclk);
      #1 o[0] = txd;
      for (int i = 1; i < 11; i++) begin
         repeat (bt) @(posedge mclk);
         #1 o[i] = txd;
      end
   endtask : decode
   initial begin
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      rchk("ctrl_rst", SPC_ADDR_CTRL, 8'hff, 8'h00);
      rchk("pwr_rst", SPC_ADDR_PWR, 8'hff, 8'h00);
      rchk("unmapped", SPC_UNMAPPED, 8'hff, 8'hff);
      chk("txd_idle", 11'h1, {10'h0, txd});
      seed = lfsr(seed);
      d = seed[7:0];
      b = seed[8];
      acc(SPC_ADDR_CTRL, 1'b1, 8'h90 | {4'h0, b, 3'h0}, v);
      acc(SPC_ADDR_BUF, 1'b1, d, v);
      decode(64, f);
      chk("tx_frame", frame(d, b), f);
      rchk("tx_done", SPC_ADDR_CTRL, 8'h02, 8'h02);
      repeat (300) @(posedge mclk);
      rchk("tx_done_held", SPC_ADDR_CTRL, 8'h02, 8'h02);
      acc(SPC_ADDR_CTRL, 1'b1, 8'h90, v);
      rchk("tx_done_clr", SPC_ADDR_CTRL, 8'h02, 8'h00);
      lastr = 8'h00;
      lb9 = 1'b0;
      for (int i = 0; i < 5; i++) begin
         acc(SPC_ADDR_CTRL, 1'b1, cc[i], v);
         if (i == 4) acc(SPC_ADDR_PWR, 1'b1, 8'h40, v);
         seed = lfsr(seed);
         spc_link_model_i.send(seed[7:0], b9v[i], stv[i], 64);
         repeat (20) @(posedge mclk);
         if (acv[i]) begin
            lastr = seed[7:0];
         end
         // the control write cleared the receive ninth bit
         lb9 = acv[i] & b9v[i];
         rchk("rx_flags", SPC_ADDR_CTRL, mk[i],
            {1'b1, 4'h0, lb9, 1'b0, acv[i]} & mk[i]);
         if (i < 4) rchk("rx_buf", SPC_ADDR_BUF, 8'hff, lastr);
         if (i == 0) rchk("rx_held", SPC_ADDR_CTRL, 8'h01, 8'h01);
      end
      repeat (300) @(posedge mclk);
      rchk("fe_held", SPC_ADDR_CTRL, 8'h80, 8'h80);
      acc(SPC_ADDR_CTRL, 1'b1, 8'h10, v);
      rchk("fe_clr", SPC_ADDR_CTRL, 8'h81, 8'h00);
      acc(SPC_ADDR_PWR, 1'b1, 8'h80, v);
      // mode 1 with filter: bad stop refused, good stop taken
      for (int i = 0; i < 2; i++) begin
         acc(SPC_ADDR_CTRL, 1'b1, 8'h70, v);
         seed = lfsr(seed);
         spc_link_model_i.send(seed[7:0], i[0], 1'b1, 64);
         repeat (20) @(posedge mclk);
         rchk("m1_flags", SPC_ADDR_CTRL, 8'h05, i ? 8'h05 : 8'h00);
         if (i) rchk("m1_buf", SPC_ADDR_BUF, 8'hff, seed[7:0]);
      end
      acc(SPC_ADDR_CTRL, 1'b1, 8'h80, v);
      fork
         begin
            n = 0;
            while (tx_ready === 1'b1 && n < 12) begin
               seed = lfsr(seed);
               sent.push_back(seed[7:0]);
               acc(SPC_ADDR_BUF, 1'b1, seed[7:0], v);
               n++;
            end
            chk("tx_refuse", 11'h0, {10'h0, tx_ready});
         end
         for (int i = 0; i < 8; i++) decode(32, fr[i]);
      join
      chk("fifo_fill", 11'h1, {10'h0, n >= SPC_FIFO_DEPTH});
      for (int i = 0; i < 8; i++) chk("tx_fifo", frame(sent[i], 1'b0), fr[i]);
      repeat (800) @(posedge mclk);
      chk("fifo_drained", 11'h1, {10'h0, tx_ready});
      for (int i = 0; i < 2; i++) begin
         acc(SPC_ADDR_CTRL, 1'b1, i ? 8'h20 : 8'h00, v);
         acc(SPC_ADDR_BUF, 1'b1, 8'h5a, v);
         wait_low(100);
         n = 0;
         while (txd === 1'b0 && n < 20) begin
            @(posedge mclk);
            #1 n++;
         end
         chk("m0_half_bit", i ? 11'h2 : 11'h6, 11'(n));
         repeat (200) @(posedge mclk);
         rchk("m0_tx_done", SPC_ADDR_CTRL, 8'h02, 8'h02);
      end
      conclude();
   end
endmodule : serial_port_control_tb
